// ### hw/rxl_policy.sv
// receive packet limit policy: per-endpoint counters, command and state registers, head byte port
`timescale 1ns/1ps

// Functional notes
// - head register returns byte zero of oldest
// - one five-bit counter per endpoint
// - stored packet decrements its endpoint counter
// - enabled zero count refuses, NAKs non-iso OUT
// - counters saturate at zero and thirty-one
// - policy per endpoint, disabled after reset
// - code 000 disables policy
// - code 001 enables policy
// - codes 010/011 decrement and increment
// - code 100 latches count and enable
// - code 111 clears and disables; 101/110 ignored
// - state bit 7 enable, bits 4:0 count
// - state bits 6:5 read zero
module rxl_policy #(
  parameter int NUM_EP = 16,
  parameter int CNT_W = 5
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [15:0] WB_ADR_IN,
  input wire logic [7:0] WB_DAT_IN,
  input wire logic WB_SEL_IN,
  output logic [7:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire rxl_pkg::rxl_token_type OUT_TOKEN_IN,
  input wire rxl_pkg::rxl_pkt_type PKT_STORED_IN,
  input wire logic [7:0] HEAD_BYTE_IN,
  output logic NAK_OUT,
  output logic REFUSE_OUT,
  output logic [NUM_EP-1:0] EP_BLOCKED_OUT
);
  // =====================================================
  // bus decode
  logic ack_reg;
  logic [7:0] dat_reg;
  logic [7:0] state_reg;
  logic [7:0] cmd_reg;
  logic nak_reg;
  logic refuse_reg;
  logic [NUM_EP-1:0] blocked_reg;

  wire logic req = WB_CYC_IN && WB_STB_IN && !ack_reg;
  wire logic hit_head = (WB_ADR_IN == rxl_pkg::OFF_HEAD);
  wire logic hit_cmd = (WB_ADR_IN == rxl_pkg::OFF_CMD);
  wire logic hit_state = (WB_ADR_IN == rxl_pkg::OFF_STATE);
  wire logic wr = req && WB_WE_IN && WB_SEL_IN;
  wire logic cmd_wr = wr && hit_cmd;
  wire logic state_wr = wr && hit_state;
  wire logic [3:0] sel_ep = WB_DAT_IN[rxl_pkg::EP_HI:0];
  wire logic [2:0] sel_cmd = WB_DAT_IN[rxl_pkg::CMD_HI:rxl_pkg::CMD_LO];

  // =====================================================
  // per-endpoint counters
  logic [CNT_W-1:0] count_arr [NUM_EP];
  logic [NUM_EP-1:0] enable_vec;
  logic [NUM_EP-1:0] zero_vec;

  function automatic logic cmd_hit(input logic [3:0] ep, input int idx,
                                   input logic [2:0] code, input logic [2:0] want);
    cmd_hit = (ep == 4'(idx)) && (code == want);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : gen_ep
      wire logic hw_dec = PKT_STORED_IN.valid && (PKT_STORED_IN.ep == 4'(g));
      rxl_counter #(.CW(CNT_W)) u_cnt (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .dec_in(hw_dec || (cmd_wr && cmd_hit(sel_ep, g, sel_cmd, rxl_pkg::CMD_DEC))),
        .inc_in(cmd_wr && cmd_hit(sel_ep, g, sel_cmd, rxl_pkg::CMD_INC)),
        .clear_in(cmd_wr && cmd_hit(sel_ep, g, sel_cmd, rxl_pkg::CMD_CLEAR)),
        .en_set_in(cmd_wr && cmd_hit(sel_ep, g, sel_cmd, rxl_pkg::CMD_ENABLE)),
        .en_clr_in(cmd_wr && cmd_hit(sel_ep, g, sel_cmd, rxl_pkg::CMD_DISABLE)),
        .count_out(count_arr[g]),
        .enable_out(enable_vec[g])
      );
      assign zero_vec[g] = (count_arr[g] == CNT_W'(0));
    end
  endgenerate

  wire logic [NUM_EP-1:0] blocked_next = zero_vec & enable_vec;
  wire logic tok_blocked = OUT_TOKEN_IN.valid && blocked_next[OUT_TOKEN_IN.ep];
  wire logic nak_next = tok_blocked && !OUT_TOKEN_IN.iso;

  wire logic [7:0] snap = {enable_vec[sel_ep], 2'b00, count_arr[sel_ep]};
  wire logic [7:0] state_next =
    (cmd_wr && sel_cmd == rxl_pkg::CMD_GET) ? snap :
    state_wr ? {WB_DAT_IN[rxl_pkg::ST_EN_BIT], 2'b00, WB_DAT_IN[rxl_pkg::CNT_HI:0]} :
    state_reg;
  // command register keeps code and endpoint, bit 4 reads zero
  wire logic [7:0] cmd_next = cmd_wr ? {sel_cmd, 1'b0, sel_ep} : cmd_reg;

  // head byte is registered into dat_reg in the request cycle and read out with the ack
  wire logic [7:0] rd_next = hit_head ? HEAD_BYTE_IN :
                             hit_cmd ? cmd_reg :
                             hit_state ? state_reg : rxl_pkg::RST_BYTE;

  // =====================================================
  // registers
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_reg <= 1'b0;
      dat_reg <= rxl_pkg::RST_BYTE;
      state_reg <= rxl_pkg::RST_BYTE;
      cmd_reg <= rxl_pkg::RST_BYTE;
      nak_reg <= 1'b0;
      refuse_reg <= 1'b0;
      blocked_reg <= '0;
    end else begin
      ack_reg <= req;
      dat_reg <= (req && !WB_WE_IN) ? rd_next : dat_reg;
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      nak_reg <= nak_next;
      refuse_reg <= tok_blocked;
      blocked_reg <= blocked_next;
    end
  end

  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = dat_reg;
  assign NAK_OUT = nak_reg;
  assign REFUSE_OUT = refuse_reg;
  assign EP_BLOCKED_OUT = blocked_reg;
endmodule

// ### include/rxl_pkg.sv
// package: register map, field layout, command codes and carrier types for the rx limit block
package rxl_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_HEAD = 16'h7FAD;
  localparam logic [15:0] OFF_CMD = 16'h7FAE;
  localparam logic [15:0] OFF_STATE = 16'h7FAF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int CMD_HI = 7;
  localparam int CMD_LO = 5;
  localparam int EP_HI = 3;
  localparam int ST_EN_BIT = 7;
  localparam int CNT_HI = 4;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [2:0] CMD_DISABLE = 3'h0;
  localparam logic [2:0] CMD_ENABLE = 3'h1;
  localparam logic [2:0] CMD_DEC = 3'h2;
  localparam logic [2:0] CMD_INC = 3'h3;
  localparam logic [2:0] CMD_GET = 3'h4;
  localparam logic [2:0] CMD_CLEAR = 3'h7;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic iso;
  } rxl_token_type;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
  } rxl_pkt_type;
endpackage

// ### hw/rxl_counter.sv
// one five-bit saturating up/down packet counter with its policy enable
`timescale 1ns/1ps
module rxl_counter #(
  parameter int CW = 5
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic dec_in,
  input wire logic inc_in,
  input wire logic clear_in,
  input wire logic en_set_in,
  input wire logic en_clr_in,
  output logic [CW-1:0] count_out,
  output logic enable_out
);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic enable_reg;
  logic enable_next;
  wire logic at_max = (count_reg == {CW{1'b1}});
  wire logic at_zero = (count_reg == '0);
  wire logic up = inc_in && !dec_in && !at_max;
  wire logic down = dec_in && !inc_in && !at_zero;

  // =====================================================
  // counting
  // saturate at both ends
  assign count_next = clear_in ? '0 :
                      up ? count_reg + CW'(1) :
                      down ? count_reg - CW'(1) : count_reg;
  assign enable_next = (clear_in || en_clr_in) ? 1'b0 : (en_set_in ? 1'b1 : enable_reg);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
      enable_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      enable_reg <= enable_next;
    end
  end

  assign count_out = count_reg;
  assign enable_out = enable_reg;
endmodule

// ### verification/rxl_policy_monitor.sv
// checker on the rx limit block ports
`timescale 1ns/1ps
module rxl_policy_monitor #(
  parameter int NUM_EP = 16
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [15:0] WB_ADR_IN,
  input wire logic [7:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire rxl_pkg::rxl_token_type OUT_TOKEN_IN,
  input wire logic [7:0] HEAD_BYTE_IN,
  input wire logic NAK_OUT,
  input wire logic REFUSE_OUT,
  input wire logic [NUM_EP-1:0] EP_BLOCKED_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  // ====================
  // bus and link checks
  AST_ACK_ONE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  AST_ACK_DUE: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("ack late");
  AST_HEAD: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == rxl_pkg::OFF_HEAD
    |-> WB_DAT_OUT == $past(HEAD_BYTE_IN))
    else $error("head byte wrong");
  AST_RSV_ZERO: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == rxl_pkg::OFF_STATE
    |-> WB_DAT_OUT[6:5] == 2'b00)
    else $error("state reserved bits set");
  AST_NAK_REF: assert property (NAK_OUT |-> REFUSE_OUT && !$past(OUT_TOKEN_IN.iso))
    else $error("nak without refusal");
  AST_REF_CAUSE: assert property (REFUSE_OUT |-> $past(OUT_TOKEN_IN.valid))
    else $error("refusal without token");
  AST_NAK_ALL: assert property (REFUSE_OUT && !$past(OUT_TOKEN_IN.iso) |-> NAK_OUT)
    else $error("refused token not naked");
  AST_REF_BLK: assert property ($past(OUT_TOKEN_IN.valid)
    |-> REFUSE_OUT == EP_BLOCKED_OUT[$past(OUT_TOKEN_IN.ep)])
    else $error("refusal differs from blocked state");
endmodule
bind rxl_policy rxl_policy_monitor #(.NUM_EP(NUM_EP)) rxl_policy_monitor_inst (.*);

// ### verification/rxl_engine_model.sv
// model of the serial engine feeding tokens and stored packets
`timescale 1ns/1ps
module rxl_engine_model (
  input wire logic clk_in,
  output rxl_pkg::rxl_token_type token_out,
  output rxl_pkg::rxl_pkt_type pkt_out,
  output logic [7:0] head_out
);
  // oldest packet is never released here, so the head byte stays put
  initial begin
    token_out = '0;
    pkt_out = '0;
    head_out = 8'hA5;
  end
  task automatic send(input logic [3:0] e, input logic iso);
    token_out <= '{1'b1, e, iso};
    @(posedge clk_in);
    token_out <= '0;
  endtask
  task automatic store(input logic [3:0] e);
    pkt_out <= '{1'b1, e};
    @(posedge clk_in);
    pkt_out <= '0;
  endtask
endmodule

// ### verification/rxl_policy_bench.sv
// self-checking bench for the rx packet limit block
`timescale 1ns/1ps
module rxl_policy_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sel = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [7:0] dat = 8'h00;
  logic [7:0] q, dout, head;
  logic ack, nak, refuse;
  logic [15:0] blk;
  rxl_pkg::rxl_token_type tok;
  rxl_pkg::rxl_pkt_type pkt;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  rxl_engine_model rxl_engine_model_inst (.clk_in(clk), .token_out(tok), .pkt_out(pkt),
    .head_out(head));
  rxl_policy rxl_policy_inst (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(dat), .WB_SEL_IN(sel),
    .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .OUT_TOKEN_IN(tok), .PKT_STORED_IN(pkt),
    .HEAD_BYTE_IN(head), .NAK_OUT(nak), .REFUSE_OUT(refuse), .EP_BLOCKED_OUT(blk));
  // ====================
  // tasks
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [15:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 1'b1;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [3:0] e);
    wb(rxl_pkg::OFF_CMD, 1'b1, {c, 1'b0, e});
  endtask
  task automatic rd(input string nm, input logic [15:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic st(input logic [3:0] e, input logic [7:0] x);
    cmd(3'h4, e);
    rd("state", rxl_pkg::OFF_STATE, x);
  endtask
  task automatic tk(input logic [3:0] e, input logic iso, input logic [1:0] x);
    rxl_engine_model_inst.send(e, iso);
    @(posedge clk);
    chk("nak_refuse", {6'h00, x}, {6'h00, nak, refuse});
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd("state_reset", rxl_pkg::OFF_STATE, 8'h00);
    rd("head", rxl_pkg::OFF_HEAD, 8'hA5);
    rd("unmapped", 16'h7FB0, 8'h00);
    tk(4'h3, 1'b0, 2'b00);
    cmd(3'h1, 4'h3);
    tk(4'h3, 1'b0, 2'b11);
    tk(4'h3, 1'b1, 2'b01);
    tk(4'h5, 1'b0, 2'b00);
    chk("blocked_lo", 8'h08, blk[7:0]);
    chk("blocked_hi", 8'h00, blk[15:8]);
    repeat (33) cmd(3'h3, 4'h3);
    st(4'h3, 8'h9F);
    chk("unblocked", 8'h00, blk[7:0]);
    rxl_engine_model_inst.store(4'h3);
    st(4'h3, 8'h9E);
    repeat (31) cmd(3'h2, 4'h3);
    st(4'h3, 8'h80);
    chk("blocked_again", 8'h08, blk[7:0]);
    rxl_engine_model_inst.store(4'h3);
    st(4'h3, 8'h80);
    cmd(3'h0, 4'h3);
    tk(4'h3, 1'b0, 2'b00);
    cmd(3'h1, 4'h3);
    cmd(3'h3, 4'h3);
    cmd(3'h5, 4'h3);
    cmd(3'h6, 4'h3);
    st(4'h3, 8'h81);
    cmd(3'h7, 4'h3);
    st(4'h3, 8'h00);
    wb(rxl_pkg::OFF_STATE, 1'b1, 8'hFF);
    rd("state_rsv", rxl_pkg::OFF_STATE, 8'h9F);
    wb(rxl_pkg::OFF_HEAD, 1'b1, 8'h00);
    rd("head_ro", rxl_pkg::OFF_HEAD, 8'hA5);
    rd("cmd_readback", rxl_pkg::OFF_CMD, 8'h83);
    chk("blocked_clear", 8'h00, blk[7:0]);
    close_out();
  end
endmodule
